// *** verilog/tbs_consts.vh ***
`ifndef TBS_CONSTS_VH
`define TBS_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TBS_IDX_TRACE_PORT 16'hf7f0
`define TBS_IDX_BP_ENABLE 16'hf7fd
`define TBS_IDX_DEBUG_STATE 16'hf7fe
`define TBS_IDX_CAUSE 16'hf7ff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TBS_RST_BP_ENABLE 16'h0000
`define TBS_RST_CAUSE 16'h0000
`define TBS_RST_ENTRY 17'h1ffff

// ----------------------------------------------------------------
// Cause register fields
// ----------------------------------------------------------------
`define TBS_CB_SOFT 15
`define TBS_CB_FORBID 14
`define TBS_CB_TFULL 13
`define TBS_CB_INT 12
`define TBS_CB_JUMP 11
`define TBS_CB_PM3 7
`define TBS_CB_PM2 6
`define TBS_CB_PM1 5
`define TBS_CB_EXT 4
`define TBS_CB_EXT_REGISTER_CAUSE 3
`define TBS_CB_COMB 2
`define TBS_CB_ADDR 1
`define TBS_CB_VALUE 0

// ----------------------------------------------------------------
// Enable register and debug state fields
// ----------------------------------------------------------------
`define TBS_EB_FORBID 14
`define TBS_EB_TFULL 12
`define TBS_DS_DEBUG 15
`define TBS_DS_BOOT 14
`define TBS_DS_TAG 0

// ----------------------------------------------------------------
// Discontinuity kinds
// ----------------------------------------------------------------
`define TBS_KIND_DIRECT 2'h0
`define TBS_KIND_INDIRECT 2'h1
`define TBS_KIND_IRQ 2'h2
`define TBS_KIND_TRAP 2'h3

`endif

// *** verilog/tbs_trace_break.v ***
`default_nettype none
`include "tbs_consts.vh"

module tbs_trace_break #(
  parameter AW = 16,
  parameter DEPTH = 16,
  parameter PW = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire flow_valid,
  input wire flow_taken,
  input wire [1:0] flow_kind,
  input wire flow_pmem_data,
  input wire [AW-1:0] flow_src_addr,
  input wire [AW-1:0] flow_dst_addr,
  input wire handler_active,
  input wire user_debug_access,
  input wire evt_trap,
  input wire evt_int,
  input wire evt_jump,
  input wire [2:0] evt_prog_match,
  input wire evt_ext,
  input wire evt_ext_reg,
  input wire evt_comb,
  input wire evt_addr,
  input wire evt_value,
  input wire debug_mode_pin,
  input wire boot_mode_pin,
  output reg bp_req
);

  // Entry width: address plus one tag bit
  localparam EW = AW + 1;
  // Depth at fill-counter width, for compares
  localparam [PW:0] DEPTH_C = DEPTH;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Stage store, head pointer and read offset.
  // Head points at the next stage to be written.
  // Read offset counts back from the newest entry.
  // Read count tells when every stage has been popped.
  // Fill counts stages written since the last readout,
  // saturating at the depth; only the full break uses it.
  reg [EW-1:0] mem_r [0:DEPTH-1];
  reg [PW-1:0] head_r;
  reg [PW-1:0] rofs_r;
  reg [PW:0] rcnt_r;
  reg [PW:0] fill_r;
  reg [15:0] enable_r;
  reg [15:0] cause_r;
  reg debug_flag_r;
  reg boot_flag_r;
  reg dbg_s1_r;
  reg dbg_s2_r;
  reg boot_s1_r;
  reg boot_s2_r;
  reg strap_done_r;
  reg handler_d_r;
  reg [PW-1:0] rd_idx;
  reg [EW-1:0] top_entry;
  reg [15:0] rd_word;
  reg rd_hit;
  reg [15:0] cause_set;
  reg rec_one;
  reg rec_two;
  reg [PW:0] fill_nxt;
  reg full_evt;
  integer i;

  // Word index of the access; byte lanes ignored
  wire [15:0] idx = paddr[17:2];
  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr_done = done & pwrite;
  wire pop = done & ~pwrite & (idx == `TBS_IDX_TRACE_PORT);
  wire last_pop = pop & (rcnt_r == DEPTH_C - 1'b1);

  // ----------------------------------------------------------------
  // Recording decision
  // ----------------------------------------------------------------
  // One report per cycle at most from the core.
  // Kinds with a coded target need only the source;
  // the reader rebuilds the target from the object code.
  // Kinds with a computed target need both addresses.
  // Trap entries and handler flow never reach the store,
  // so the handler can read the trace without disturbing it.
  always @* begin
    rec_one = 1'b0;
    rec_two = 1'b0;
    if (flow_valid && flow_taken && !handler_active &&
        !flow_pmem_data) begin
      case (flow_kind)
        `TBS_KIND_DIRECT: rec_one = 1'b1;
        `TBS_KIND_INDIRECT: rec_two = 1'b1;
        `TBS_KIND_IRQ: rec_two = 1'b1;
        `TBS_KIND_TRAP: rec_two = 1'b0;
        default: rec_one = 1'b0;
      endcase
    end
  end

  // Fill level and full event
  // Full fires once, on the step that reaches the depth;
  // a pair that overshoots still counts as reaching it.
  // Fill is cleared only by a complete readout, so the
  // break cannot fire again until the reader has emptied it.
  always @* begin
    fill_nxt = fill_r;
    if (rec_one)
      fill_nxt = fill_r + 1'b1;
    else if (rec_two)
      fill_nxt = fill_r + 2'd2;
    if (fill_nxt > DEPTH_C)
      fill_nxt = DEPTH_C;
    full_evt = enable_r[`TBS_EB_TFULL] && (fill_r < DEPTH_C) &&
               (fill_nxt == DEPTH_C);
  end

  // ----------------------------------------------------------------
  // Trace memory
  // ----------------------------------------------------------------
  // A readout that ends in the same cycle as a recording
  // loses the recording only if it is the sixteenth pop;
  // otherwise the recording wins and the read restarts.
  // Pairs are written source first, target above it, so
  // reading newest first yields the target, then source.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_r[i] <= `TBS_RST_ENTRY;
      head_r <= {PW{1'b0}};
    end else begin
      if (last_pop) begin
        for (i = 0; i < DEPTH; i = i + 1)
          mem_r[i] <= `TBS_RST_ENTRY;
      end else if (rec_one) begin
        mem_r[head_r] <= {flow_src_addr, 1'b1};
        head_r <= head_r + 1'b1;
      end else if (rec_two) begin
        mem_r[head_r] <= {flow_src_addr, 1'b0};
        mem_r[head_r + 1'b1] <= {flow_dst_addr, 1'b0};
        head_r <= head_r + 2'd2;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_r <= {(PW+1){1'b0}};
    end else if (last_pop) begin
      fill_r <= {(PW+1){1'b0}};
    end else begin
      fill_r <= fill_nxt;
    end
  end

  // Read position, newest first
  // Any new entry moves the read point back to the top,
  // since the offset is relative to the head pointer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rofs_r <= {PW{1'b0}};
      rcnt_r <= {(PW+1){1'b0}};
    end else if (last_pop || rec_one || rec_two) begin
      rofs_r <= {PW{1'b0}};
      rcnt_r <= {(PW+1){1'b0}};
    end else if (pop) begin
      rofs_r <= rofs_r + 1'b1;
      rcnt_r <= rcnt_r + 1'b1;
    end
  end

  always @* begin
    rd_idx = head_r - 1'b1 - rofs_r;
    top_entry = mem_r[rd_idx];
  end

  // ----------------------------------------------------------------
  // Mode pins
  // ----------------------------------------------------------------
  // Synchronisers run through reset on purpose: a reset
  // value here would hide the pin level at release and the
  // flags would always read zero. The pins must be steady
  // for two clocks before reset is let go.
  always @(posedge pclk) begin
    dbg_s1_r <= debug_mode_pin;
    dbg_s2_r <= dbg_s1_r;
    boot_s1_r <= boot_mode_pin;
    boot_s2_r <= boot_s1_r;
  end

  // flags caught once after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_r <= 1'b0;
      debug_flag_r <= 1'b0;
      boot_flag_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      debug_flag_r <= dbg_s2_r;
      boot_flag_r <= boot_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Breakpoint causes
  // ----------------------------------------------------------------
  // Comparator events arrive already gated by their enables.
  // Only the forbidden access and the full break are gated
  // here, as their enables live in this block.
  // Unused cause positions always read zero.
  always @* begin
    cause_set = 16'h0000;
    cause_set[`TBS_CB_SOFT] = evt_trap;
    cause_set[`TBS_CB_INT] = evt_int;
    cause_set[`TBS_CB_FORBID] = user_debug_access & ~handler_active &
                                enable_r[`TBS_EB_FORBID];
    cause_set[`TBS_CB_TFULL] = full_evt;
    cause_set[`TBS_CB_JUMP] = evt_jump;
    cause_set[`TBS_CB_PM3] = evt_prog_match[2];
    cause_set[`TBS_CB_PM2] = evt_prog_match[1];
    cause_set[`TBS_CB_PM1] = evt_prog_match[0];
    cause_set[`TBS_CB_EXT] = evt_ext;
    cause_set[`TBS_CB_EXT_REGISTER_CAUSE] = evt_ext_reg;
    cause_set[`TBS_CB_COMB] = evt_comb;
    cause_set[`TBS_CB_ADDR] = evt_addr;
    cause_set[`TBS_CB_VALUE] = evt_value;
  end

  // held until handler ends, set wins
  // Causes accumulate while the handler runs, so the
  // handler sees every source of the current break.
  // Clearing on handler exit readies the register for
  // the next break; an event in that cycle still lands.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= `TBS_RST_CAUSE;
      handler_d_r <= 1'b0;
      bp_req <= 1'b0;
    end else begin
      handler_d_r <= handler_active;
      if (handler_d_r && !handler_active)
        cause_r <= cause_set;
      else
        cause_r <= cause_r | cause_set;
      bp_req <= |cause_set;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read mux for the mapped words; others flag an error.
  // The trace port shows the address part of the stage,
  // the tag goes out through the debug state word.
  // Reading the tag never moves the read point; only the
  // trace port read does, and only on its access edge.
  always @* begin
    rd_hit = 1'b1;
    rd_word = 16'h0000;
    case (idx)
      `TBS_IDX_TRACE_PORT: rd_word = top_entry[EW-1:1];
      `TBS_IDX_BP_ENABLE: rd_word = enable_r;
      `TBS_IDX_DEBUG_STATE: begin
        rd_word[`TBS_DS_DEBUG] = debug_flag_r;
        rd_word[`TBS_DS_BOOT] = boot_flag_r;
        rd_word[`TBS_DS_TAG] = top_entry[0];
      end
      `TBS_IDX_CAUSE: rd_word = cause_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer one cycle after setup
  // Read data is captured at the setup edge and held
  // through the access cycle, so it matches the entry
  // that the pop at the access edge then retires.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : {16'h0000, rd_word};
      pready <= 1'b1;
      pslverr <= ~rd_hit;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Breakpoint enable register
  // Written on the access edge; other bits are kept for
  // the comparators outside, which see them elsewhere.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      enable_r <= `TBS_RST_BP_ENABLE;
    else if (wr_done && idx == `TBS_IDX_BP_ENABLE)
      enable_r <= pwdata[15:0];
  end

endmodule // tbs_trace_break
`default_nettype wire

// *** testbench/tbs_trace_break_monitor.sv ***
`default_nettype none
module tbs_trace_break_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic flow_valid,
  input wire logic user_debug_access,
  input wire logic evt_trap,
  input wire logic evt_int,
  input wire logic evt_jump,
  input wire logic [2:0] evt_prog_match,
  input wire logic evt_ext,
  input wire logic evt_ext_reg,
  input wire logic evt_comb,
  input wire logic evt_addr,
  input wire logic evt_value,
  input wire logic bp_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic any_cause;
  // Any source that may request a break
  assign any_cause = flow_valid | user_debug_access | evt_trap | evt_int |
    evt_jump | (|evt_prog_match) | evt_ext | evt_ext_reg | evt_comb |
    evt_addr | evt_value;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cause pulses request a break next cycle
  property p_trap; evt_trap |=> bp_req; endproperty
  a_trap: assert property (p_trap) else $error("trap missed");
  property p_int; evt_int |=> bp_req; endproperty
  a_int: assert property (p_int) else $error("irq missed");
  property p_jump; evt_jump |=> bp_req; endproperty
  a_jump: assert property (p_jump) else $error("jump missed");
  property p_prog; |evt_prog_match |=> bp_req; endproperty
  a_prog: assert property (p_prog) else $error("match missed");
  property p_ext; (evt_ext || evt_ext_reg) |=> bp_req; endproperty
  a_ext: assert property (p_ext) else $error("ext missed");
  property p_data; (evt_comb || evt_addr || evt_value) |=> bp_req; endproperty
  a_data: assert property (p_data) else $error("data missed");
  // No break without a cause
  property p_spur; bp_req |-> $past(any_cause); endproperty
  a_spur: assert property (p_spur) else $error("stray break");
  // Every access answers after one setup
  property p_ready; psel && !penable |=> pready && penable; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
endmodule // tbs_trace_break_monitor

bind tbs_trace_break tbs_trace_break_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .flow_valid(flow_valid),
  .user_debug_access(user_debug_access), .evt_trap(evt_trap),
  .evt_int(evt_int), .evt_jump(evt_jump), .evt_prog_match(evt_prog_match),
  .evt_ext(evt_ext), .evt_ext_reg(evt_ext_reg), .evt_comb(evt_comb),
  .evt_addr(evt_addr), .evt_value(evt_value), .bp_req(bp_req));
`default_nettype wire

// *** testbench/tbs_dbg_reader.sv ***
`default_nettype none
module tbs_dbg_reader (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [17:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic to = 1'b0;
  // Idle bus
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
  end
  // Setup then access, held until ready
  task automatic xfer(input logic w, input logic [15:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    to = to | (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // tbs_dbg_reader
`default_nettype wire

// *** testbench/tbs_trace_break_bench.sv ***
`default_nettype none
module tbs_trace_break_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, bp_req;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic fv = 1'b0, ft = 1'b0, fp = 1'b0, hnd = 1'b0;
  logic [1:0] fk = 2'h0;
  logic [15:0] fs = 16'h0, fd = 16'h0;
  logic [11:0] ev = 12'h0;
  logic [16:0] exq[$];
  int bad_count = 0, compares = 0;
  int pos[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 11, 12, 14, 15};
  // Clock
  always #20 pclk = ~pclk;
  tbs_trace_break dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flow_valid(fv),
    .flow_taken(ft), .flow_kind(fk), .flow_pmem_data(fp),
    .flow_src_addr(fs), .flow_dst_addr(fd), .handler_active(hnd),
    .user_debug_access(ev[10]), .evt_trap(ev[11]), .evt_int(ev[9]),
    .evt_jump(ev[8]), .evt_prog_match(ev[7:5]), .evt_ext(ev[4]),
    .evt_ext_reg(ev[3]), .evt_comb(ev[2]), .evt_addr(ev[1]),
    .evt_value(ev[0]), .debug_mode_pin(1'b1), .boot_mode_pin(1'b0),
    .bp_req(bp_req));
  tbs_dbg_reader u_rd (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  task automatic end_sim();
    bad_count += u_rd.to;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus access with its error answer judged
  task automatic xf(input logic w, input logic [15:0] i,
    input logic [31:0] wd, input logic eo);
    logic er;
    u_rd.xfer(w, i, wd, d, er);
    chk({31'h0, er}, {31'h0, eo});
    if (u_rd.to) end_sim();
  endtask
  // One core discontinuity report
  task automatic rec(input logic [1:0] k, input logic [15:0] s, dd,
    input logic [2:0] f);
    @(posedge pclk);
    fv <= 1'b1;
    fk <= k;
    fs <= s;
    fd <= dd;
    {ft, fp, hnd} <= f;
    @(posedge pclk);
    fv <= 1'b0;
    hnd <= 1'b0;
  endtask
  task automatic drain();
    logic [16:0] e;
    for (int n = 0; n < 16; n++) begin
      e = exq.size() ? exq.pop_front() : 17'h1ffff;
      xf(0, 16'hf7fe, 0, 0);
      chk(d, {16'h0, 2'b10, 13'h0, e[0]});
      xf(0, 16'hf7f0, 0, 0);
      chk(d, {16'h0, e[16:1]});
    end
    exq = {};
  endtask
  // Cause read in handler, cleared after it
  task automatic hcause(input logic [31:0] exp);
    @(posedge pclk);
    hnd <= 1'b1;
    xf(0, 16'hf7ff, 0, 0);
    chk(d, exp);
    @(posedge pclk);
    hnd <= 1'b0;
    repeat (2) @(posedge pclk);
    xf(0, 16'hf7ff, 0, 0);
    chk(d, 0);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xf(0, 16'h0000, 0, 1);
    chk(d, 0);
    hcause(0);
    drain();
    $display("test reset done");
    rec(2'h0, 16'h1234, 16'h0, 3'b100);
    exq.push_front({16'h1234, 1'b1});
    rec(2'h1, 16'h2000, 16'h3000, 3'b100);
    exq.push_front({16'h2000, 1'b0});
    exq.push_front({16'h3000, 1'b0});
    rec(2'h2, 16'h0111, 16'h0008, 3'b100);
    exq.push_front({16'h0111, 1'b0});
    exq.push_front({16'h0008, 1'b0});
    rec(2'h0, 16'h5555, 16'h0, 3'b000);
    rec(2'h0, 16'h6666, 16'h0, 3'b110);
    rec(2'h1, 16'h7777, 16'h7778, 3'b101);
    rec(2'h3, 16'h8888, 16'h9999, 3'b100);
    drain();
    drain();
    $display("test flow done");
    xf(1, 16'hf7fd, 32'h1000, 0);
    for (int n = 0; n < 16; n++) begin
      rec(2'h0, 16'(n), 16'h0, 3'b100);
      exq.push_front({16'(n), 1'b1});
    end
    hcause(32'h2000);
    drain();
    xf(1, 16'hf7fd, 32'h4000, 0);
    for (int n = 0; n < 17; n++) begin
      rec(2'h0, 16'h0100 + 16'(n), 16'h0, 3'b100);
      exq.push_front({16'h0100 + 16'(n), 1'b1});
    end
    hcause(0);
    drain();
    $display("test full done");
    for (int i = 0; i < 12; i++) begin
      @(posedge pclk);
      ev <= 12'h1 << i;
      @(posedge pclk);
      ev <= 12'h0;
      hcause(32'h1 << pos[i]);
    end
    $display("test causes done");
    end_sim();
  end
endmodule // tbs_trace_break_bench
`default_nettype wire
